// ==== udc_counter_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "udc_consts.svh"

module udc_counter_bank (
    input  wire logic                     I_CLOCK,        // 50 MHz system clock
    input  wire logic                     I_RST,          // Synchronous reset, active high
    input  wire logic [`UDC_ADDR_W-1:0]   I_ADDR,         // Byte address
    input  wire logic [`UDC_DATA_W-1:0]   I_WDATA,        // Write data
    input  wire logic                     I_WRITE,        // Write strobe
    input  wire logic                     I_READ,         // Read strobe
    output logic      [`UDC_DATA_W-1:0]   O_RDATA,        // Read data, cycle after strobe
    output logic      [`UDC_NUM_CNT-1:0]  O_ZERO_STATUS   // One bit per counter, count is zero
);

    udc_mem_if mem_bus ();

    // Last written input levels per counter: up, down, enable, preset load
    logic [`UDC_CTRL_W-1:0]  ctrl_q [0:`UDC_NUM_CNT-1];
    logic [`UDC_CNT_W-1:0]   preset_q;

    // Decoded access
    logic [1:0]                 area;
    logic [`UDC_IDX_W-1:0]      idx;
    logic [`UDC_STAT_SEL_W-1:0] stat_sel;
    logic                       stat_ok;
    logic                       wr_ctrl;
    logic                       wr_preset;

    // Control word in flight
    logic [`UDC_CTRL_W-1:0]  ctrl_old;
    logic [`UDC_CTRL_W-1:0]  ctrl_new;
    logic                    up_rise;
    logic                    down_rise;
    logic                    load_rise;
    logic                    enabled;
    udc_pkg::udc_op_type     op;

    // Read data for everything that is not a count
    logic [`UDC_DATA_W-1:0]  alt_data;

    // One rising-edge test shared by all three edge inputs
    function automatic logic rise(
        input logic level_new,
        input logic level_old
    );
        return level_new & ~level_old;
    endfunction

    // Count-up and count-down merge into one op; preset wins over both
    function automatic udc_pkg::udc_op_type pick_op(
        input logic load,
        input logic en,
        input logic up,
        input logic down
    );
        udc_pkg::udc_op_type res;
        res = udc_pkg::UDC_OP_NONE;
        if (load) begin
            res = udc_pkg::UDC_OP_LOAD;
        end else if (en && up && !down) begin
            res = udc_pkg::UDC_OP_INC;
        end else if (en && down && !up) begin
            res = udc_pkg::UDC_OP_DEC;
        end else begin
            res = udc_pkg::UDC_OP_NONE;
        end
        return res;
    endfunction

    // Address decode
    always_comb begin
        area      = I_ADDR[`UDC_AREA_HI:`UDC_AREA_LO];
        idx       = I_ADDR[`UDC_IDX_HI:`UDC_IDX_LO];
        stat_sel  = I_ADDR[`UDC_STAT_SEL_HI:`UDC_STAT_SEL_LO];
        stat_ok   = (I_ADDR[`UDC_STAT_PAD_HI:`UDC_STAT_PAD_LO] == `UDC_STAT_PAD_W'h0);
        wr_ctrl   = 1'b0;
        wr_preset = 1'b0;
        if (!I_WRITE) begin
            wr_ctrl   = 1'b0;
            wr_preset = 1'b0;
        end else if (area == `UDC_AREA_CTRL) begin
            wr_ctrl   = 1'b1;
        end else if (I_ADDR == `UDC_PRESET_ADDR) begin
            wr_preset = 1'b1;
        end else begin
            wr_ctrl   = 1'b0;
            wr_preset = 1'b0;
        end
    end

    // Edge detection against the levels the controller wrote last time
    always_comb begin
        ctrl_old  = ctrl_q[idx];
        ctrl_new  = I_WDATA[`UDC_CTRL_W-1:0];
        up_rise   = rise(ctrl_new[`UDC_CTRL_UP], ctrl_old[`UDC_CTRL_UP]);
        down_rise = rise(ctrl_new[`UDC_CTRL_DOWN], ctrl_old[`UDC_CTRL_DOWN]);
        load_rise = rise(ctrl_new[`UDC_CTRL_LOAD], ctrl_old[`UDC_CTRL_LOAD]);
        // The enable written with the edge is the one that governs it
        enabled   = ctrl_new[`UDC_CTRL_EN];
        // Without enable, up and down edges are dropped, not queued
        op        = pick_op(load_rise, enabled, up_rise, down_rise);
    end

    // Update port of the count store
    always_comb begin
        mem_bus.upd_en    = wr_ctrl && (op != udc_pkg::UDC_OP_NONE);
        mem_bus.upd_idx   = idx;
        mem_bus.upd_op    = op;
        // Preset value comes from the register the controller filled beforehand
        mem_bus.upd_value = preset_q;
    end

    // Levels remembered per counter; edges are only seen from written levels
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            for (int i = 0; i < `UDC_NUM_CNT; i++) begin
                ctrl_q[i] <= `UDC_CTRL_RST;
            end
        end else if (wr_ctrl) begin
            ctrl_q[idx] <= ctrl_new;
        end
    end

    // Preset value register
    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            preset_q <= `UDC_PRESET_RST;
        end else if (wr_preset) begin
            preset_q <= I_WDATA;
        end
    end

    // Read data for control, preset and status words; unmapped reads give zero
    always_comb begin
        alt_data = `UDC_RDATA_IDLE;
        if (area == `UDC_AREA_CTRL) begin
            alt_data = {{(`UDC_DATA_W-`UDC_CTRL_W){1'b0}}, ctrl_q[idx]};
        end else if (I_ADDR == `UDC_PRESET_ADDR) begin
            alt_data = preset_q;
        end else if (area == `UDC_AREA_STAT && stat_ok) begin
            alt_data = mem_bus.zero_vec[stat_sel*`UDC_STAT_WORD_W +: `UDC_STAT_WORD_W];
        end else begin
            alt_data = `UDC_RDATA_IDLE;
        end
    end

    // Read port; the memory registers the result so it stands one cycle only
    always_comb begin
        mem_bus.rd_en       = I_READ;
        mem_bus.rd_idx      = idx;
        // Counts are read raw; their sign is the software's view of bit 31
        mem_bus.rd_alt      = (area != `UDC_AREA_COUNT);
        mem_bus.rd_alt_data = alt_data;
    end

    // Count store with registered read data and zero flags
    udc_count_mem u_mem (
        .i_clock (I_CLOCK),
        .i_rst   (I_RST),
        .port    (mem_bus)
    );

    // Both outputs are flip-flops inside the count store
    assign O_RDATA       = mem_bus.rd_data;
    assign O_ZERO_STATUS = mem_bus.zero_vec;

endmodule

`default_nettype wire

// ==== udc_consts.svh ====
`ifndef UDC_CONSTS_SVH
`define UDC_CONSTS_SVH

// Bank geometry
`define UDC_NUM_CNT      256
`define UDC_CNT_W        32
`define UDC_IDX_W        8
`define UDC_ADDR_W       12
`define UDC_DATA_W       32

// Address areas, selected by address bits 11:10
`define UDC_AREA_HI      11
`define UDC_AREA_LO      10
`define UDC_IDX_HI       9
`define UDC_IDX_LO       2
`define UDC_AREA_COUNT   2'h0
`define UDC_AREA_CTRL    2'h1
`define UDC_AREA_MISC    2'h2
`define UDC_AREA_STAT    2'h3

// Fixed registers
`define UDC_PRESET_ADDR  12'h800
`define UDC_STAT_SEL_HI  4
`define UDC_STAT_SEL_LO  2
`define UDC_STAT_SEL_W   3
`define UDC_STAT_PAD_HI  9
`define UDC_STAT_PAD_LO  5
`define UDC_STAT_PAD_W   5
`define UDC_STAT_WORD_W  32

// Per-counter control word layout
`define UDC_CTRL_W       4
`define UDC_CTRL_UP      0
`define UDC_CTRL_DOWN    1
`define UDC_CTRL_EN      2
`define UDC_CTRL_LOAD    3

// Reset values
`define UDC_CTRL_RST     4'h4
`define UDC_PRESET_RST   32'h0000_0000
`define UDC_COUNT_RST    32'h0000_0000
`define UDC_COUNT_ONE    32'h0000_0001
`define UDC_RDATA_IDLE   32'h0000_0000
`define UDC_ZERO_RST     256'h0

`endif

// ==== udc_pkg.sv ====
`default_nettype none

package udc_pkg;

    // Update applied to one counter in one clock cycle
    typedef enum logic [3:0] {
        UDC_OP_NONE = 4'b0001,
        UDC_OP_INC  = 4'b0010,
        UDC_OP_DEC  = 4'b0100,
        UDC_OP_LOAD = 4'b1000
    } udc_op_type;

endpackage

`default_nettype wire

// ==== udc_mem_if.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "udc_consts.svh"

interface udc_mem_if;

    // Update port
    logic                      upd_en;
    logic [`UDC_IDX_W-1:0]     upd_idx;
    udc_pkg::udc_op_type       upd_op;
    logic [`UDC_CNT_W-1:0]     upd_value;
    // Read port, data registered in the memory
    logic                      rd_en;
    logic [`UDC_IDX_W-1:0]     rd_idx;
    logic                      rd_alt;
    logic [`UDC_DATA_W-1:0]    rd_alt_data;
    logic [`UDC_DATA_W-1:0]    rd_data;
    // Zero flags of all counters
    logic [`UDC_NUM_CNT-1:0]   zero_vec;

    modport ctrl (
        output upd_en, upd_idx, upd_op, upd_value,
        output rd_en, rd_idx, rd_alt, rd_alt_data,
        input  rd_data, zero_vec
    );

    modport mem (
        input  upd_en, upd_idx, upd_op, upd_value,
        input  rd_en, rd_idx, rd_alt, rd_alt_data,
        output rd_data, zero_vec
    );

endinterface

`default_nettype wire

// ==== udc_count_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "udc_consts.svh"

module udc_count_mem (
    input  wire logic i_clock,   // System clock
    input  wire logic i_rst,     // Synchronous reset, active high
    udc_mem_if.mem    port       // Update and read port
);

    logic [`UDC_CNT_W-1:0]   count_q [0:`UDC_NUM_CNT-1];
    logic [`UDC_DATA_W-1:0]  rd_q;
    logic [`UDC_NUM_CNT-1:0] zero_q;
    logic [`UDC_CNT_W-1:0]   next_count;

    // Next value of the addressed counter; wraps silently past the signed range
    function automatic logic [`UDC_CNT_W-1:0] step(
        input logic [`UDC_CNT_W-1:0] cur,
        input udc_pkg::udc_op_type   op,
        input logic [`UDC_CNT_W-1:0] value
    );
        logic [`UDC_CNT_W-1:0] res;
        res = cur;
        case (op)
            udc_pkg::UDC_OP_INC:  res = cur + `UDC_COUNT_ONE;
            udc_pkg::UDC_OP_DEC:  res = cur - `UDC_COUNT_ONE;
            udc_pkg::UDC_OP_LOAD: res = value;
            default:              res = cur;
        endcase
        return res;
    endfunction

    // Only one counter changes per cycle, so one adder serves the whole bank
    always_comb begin
        next_count = step(count_q[port.upd_idx], port.upd_op, port.upd_value);
    end

    // Count storage
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            for (int i = 0; i < `UDC_NUM_CNT; i++) begin
                count_q[i] <= `UDC_COUNT_RST;
            end
        end else if (port.upd_en) begin
            count_q[port.upd_idx] <= next_count;
        end
    end

    // Zero flags follow the stored count in the same edge
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            zero_q <= ~`UDC_ZERO_RST;
        end else if (port.upd_en) begin
            zero_q[port.upd_idx] <= (next_count == `UDC_COUNT_RST);
        end
    end

    // Registered read: data stand one cycle, zero otherwise
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            rd_q <= `UDC_RDATA_IDLE;
        end else if (port.rd_en) begin
            rd_q <= port.rd_alt ? port.rd_alt_data : count_q[port.rd_idx];
        end else begin
            rd_q <= `UDC_RDATA_IDLE;
        end
    end

    assign port.rd_data  = rd_q;
    assign port.zero_vec = zero_q;

endmodule

`default_nettype wire

// ==== udc_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "udc_consts.svh"

module udc_monitor (
    input wire logic                    I_CLOCK,       // System clock
    input wire logic                    I_RST,         // Synchronous reset
    input wire logic [`UDC_ADDR_W-1:0]  I_ADDR,        // Byte address
    input wire logic [`UDC_DATA_W-1:0]  I_WDATA,       // Write data
    input wire logic                    I_WRITE,       // Write strobe
    input wire logic                    I_READ,        // Read strobe
    input wire logic [`UDC_DATA_W-1:0]  O_RDATA,       // Read data
    input wire logic [`UDC_NUM_CNT-1:0] O_ZERO_STATUS  // Zero flags
);
    // One clock domain, so clock and reset are stated once
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);

    // Reset is itself the antecedent here, so it must not disable
    rst_state_a: assert property (
        disable iff (1'b0) I_RST |=> &O_ZERO_STATUS && O_RDATA == 32'h0)
        else $error("bad state after reset");
    idle_rdata_a: assert property (!I_READ |=> O_RDATA == 32'h0)
        else $error("read data without read");
    // Only writes may move a count, hence a zero flag
    zero_hold_a: assert property (!I_WRITE |=> $stable(O_ZERO_STATUS))
        else $error("zero flags moved without write");
    write_area_a: assert property (
        I_WRITE && I_ADDR[11:10] != 2'h1 |=> $stable(O_ZERO_STATUS))
        else $error("non-control write moved a flag");
    en_off_a: assert property (
        I_WRITE && I_ADDR[11:10] == 2'h1 && I_WDATA[3:2] == 2'h0 |=> $stable(O_ZERO_STATUS))
        else $error("disabled counter moved");
    one_counter_a: assert property (
        I_WRITE && I_ADDR[11:10] == 2'h1
        |=> ((O_ZERO_STATUS ^ $past(O_ZERO_STATUS)) & ~(256'h1 << $past(I_ADDR[9:2]))) == 256'h0)
        else $error("write touched another counter");
    // Both read views of one counter must agree
    count_view_a: assert property (
        I_READ && I_ADDR[11:10] == 2'h0
        |=> (O_RDATA == 32'h0) == O_ZERO_STATUS[$past(I_ADDR[9:2])])
        else $error("count and zero flag disagree");
    stat_view_a: assert property (
        I_READ && I_ADDR == 12'hc00 |=> O_RDATA == O_ZERO_STATUS[31:0])
        else $error("status word mismatch");
    ctrl_pad_a: assert property (
        I_READ && I_ADDR[11:10] == 2'h1 |=> O_RDATA[31:4] == 28'h0)
        else $error("control word padding set");
    unmapped_a: assert property (
        I_READ && I_ADDR[11:10] == 2'h2 && I_ADDR[9:2] != 8'h0 |=> O_RDATA == 32'h0)
        else $error("unmapped read not zero");
endmodule

`default_nettype wire

// ==== udc_scan_model.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "udc_consts.svh"

module udc_scan_model (
    input  wire logic                   i_clock,  // System clock
    input  wire logic [`UDC_DATA_W-1:0] i_rdata,  // Read data
    output logic      [`UDC_ADDR_W-1:0] o_addr,   // Byte address
    output logic      [`UDC_DATA_W-1:0] o_wdata,  // Write data
    output logic                        o_write,  // Write strobe
    output logic                        o_read    // Read strobe
);
    // Bus quiet at time zero
    initial begin
        o_addr = 12'h0;
        o_wdata = 32'h0;
        o_write = 1'b0;
        o_read = 1'b0;
    end

    // Strobe left up so that writes follow with no gap; the next rd call lowers it
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clock);
        o_addr <= a;
        o_wdata <= d;
        o_write <= 1'b1;
        o_read <= 1'b0;
    endtask

    // Write data is scrambled while unused, so stale values never help the design
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge i_clock);
        o_addr <= a;
        o_wdata <= ~o_wdata;
        o_write <= 1'b0;
        o_read <= 1'b1;
        @(posedge i_clock);
        o_read <= 1'b0;
        #1 d = i_rdata;
    endtask
endmodule

`default_nettype wire

// ==== test_udc_counter_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "udc_consts.svh"

module test_udc_counter_bank;
    logic                    clk = 1'b0;
    logic                    rst = 1'b1;
    logic [`UDC_ADDR_W-1:0]  addr;
    logic [`UDC_DATA_W-1:0]  wdata;
    logic [`UDC_DATA_W-1:0]  rdata;
    logic                    wr_s;
    logic                    rd_s;
    logic [`UDC_NUM_CNT-1:0] zero;
    int                      fail_count = 0;
    int                      n_tests = 0;

    // 50 MHz clock
    always #10 clk = ~clk;

    udc_counter_bank udc_counter_bank_inst (.I_CLOCK(clk), .I_RST(rst), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WRITE(wr_s), .I_READ(rd_s), .O_RDATA(rdata), .O_ZERO_STATUS(zero));
    udc_scan_model scan_inst (.i_clock(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
        .o_write(wr_s), .o_read(rd_s));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        scan_inst.rd(a, d);
        check(d, e);
    endtask

    // Counter inputs are levels in the control word; edges come from successive writes
    task automatic ctl(input logic [7:0] n, input logic [3:0] w);
        scan_inst.wr(12'h400 + {2'h0, n, 2'h0}, {28'h0, w});
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Guard against a hung run
    initial begin
        #100000;
        fail_count++;
        report_and_stop();
    end

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rchk(12'h400, 32'h4);
        rchk(12'h000, 32'h0);
        rchk(12'hc00, 32'hffffffff);
        rchk(12'h800, 32'h0);
        // Two up pulses, then three down pulses, then one up back to zero
        repeat (2) begin
            ctl(8'h05, 4'h5);
            ctl(8'h05, 4'h4);
        end
        rchk(12'h014, 32'h2);
        check({31'h0, zero[5]}, 32'h0);
        repeat (3) begin
            ctl(8'h05, 4'h6);
            ctl(8'h05, 4'h4);
        end
        rchk(12'h014, 32'hffffffff);
        ctl(8'h05, 4'h5);
        ctl(8'h05, 4'h4);
        rchk(12'h014, 32'h0);
        check({31'h0, zero[5]}, 32'h1);
        // Edges while disabled are dropped for good; simultaneous up and down edges cancel
        ctl(8'h05, 4'h1);
        ctl(8'h05, 4'h0);
        ctl(8'h05, 4'h2);
        ctl(8'h05, 4'h4);
        rchk(12'h014, 32'h0);
        ctl(8'h05, 4'h7);
        ctl(8'h05, 4'h4);
        rchk(12'h014, 32'h0);
        // Preset beats simultaneous up and down, then wraps on increment
        scan_inst.wr(12'h800, 32'h7fffffff);
        rchk(12'h800, 32'h7fffffff);
        ctl(8'h05, 4'hf);
        ctl(8'h05, 4'h4);
        rchk(12'h014, 32'h7fffffff);
        ctl(8'h05, 4'h5);
        rchk(12'h014, 32'h80000000);
        scan_inst.wr(12'h800, 32'h0);
        ctl(8'h05, 4'h8);
        rchk(12'h014, 32'h0);
        rchk(12'h414, 32'h8);
        // Last counter is independent of its neighbour
        ctl(8'hff, 4'h5);
        rchk(12'h3fc, 32'h1);
        rchk(12'h3f8, 32'h0);
        rchk(12'hc1c, 32'h7fffffff);
        // Count area is read only, unmapped space reads zero
        scan_inst.wr(12'h014, 32'h1234);
        rchk(12'h014, 32'h0);
        rchk(12'h900, 32'h0);
        // Status area is read only as well
        scan_inst.wr(12'hc00, 32'h0);
        rchk(12'hc00, 32'hffffffff);
        report_and_stop();
    end
endmodule

bind udc_counter_bank udc_monitor udc_monitor_inst (.I_CLOCK, .I_RST, .I_ADDR, .I_WDATA,
    .I_WRITE, .I_READ, .O_RDATA, .O_ZERO_STATUS);

`default_nettype wire
